// ===== rtl/timer_pair_defs.vh
`ifndef TIMER_PAIR_DEFS_VH
`define TIMER_PAIR_DEFS_VH
// timer control register bit positions
`define TCR_T1_OVF     7
`define TCR_T1_RUN     6
`define TCR_T0_OVF     5
`define TCR_T0_RUN     4
`define TCR_X1_FLAG    3
`define TCR_X1_TYPE    2
`define TCR_X0_FLAG    1
`define TCR_X0_TYPE    0
// mode register bit positions
`define TMR_T1_GATE    7
`define TMR_T1_SRC     6
`define TMR_T1_MODE_H  5
`define TMR_T1_MODE_L  4
`define TMR_T0_GATE    3
`define TMR_T0_SRC     2
`define TMR_T0_MODE_H  1
`define TMR_T0_MODE_L  0
// mode field codes
`define MODE_13BIT     2'h0
`define MODE_16BIT     2'h1
`define MODE_RELOAD    2'h2
`define MODE_SPLIT     2'h3
// reset values
`define CTRL_RESET     8'h00
`define MODEREG_RESET  8'h00
`define COUNT_RESET    8'h00
// system clocks per peripheral cycle
`define PER_CYCLE_DIV  6
`define PRESCALE_MASK  8'h1F
`define PRESCALE_TOP   8'h1F
`define BYTE_TOP       8'hFF
`define BYTE_ONE       8'h01
`endif

// ===== rtl/pin_sync.v
`include "timer_pair_defs.vh"
module pin_sync (
	// clock and reset
	input  wire CLK_SYS,
	input  wire RST_N,
	// pin and result
	input  wire pin_in,
	output reg  pin_sync_out
);

	reg meta_reg;

	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			meta_reg     <= 1'b0;
			pin_sync_out <= 1'b0;
		end else begin
			meta_reg     <= pin_in;
			pin_sync_out <= meta_reg;
		end
	end

endmodule

// ===== rtl/cycle_divider.v
`include "timer_pair_defs.vh"
module cycle_divider #(
	parameter DIV = `PER_CYCLE_DIV
) (
	// clock and reset
	input  wire CLK_SYS,
	input  wire RST_N,
	// one-cycle pulse each peripheral cycle
	output reg  tick
);

	// the count register is four bits wide, so keep the low bits on purpose
	localparam [31:0] LAST_FULL = DIV - 1;
	localparam [3:0]  LAST      = LAST_FULL[3:0];
	reg [3:0] count_reg;

	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			count_reg <= 4'h0;
			tick      <= 1'b0;
		end else begin
			tick <= (count_reg == LAST);
			if (count_reg == LAST)
				count_reg <= 4'h0;
			else
				count_reg <= count_reg + 4'h1;
		end
	end

endmodule

// ===== rtl/dual_timer_counter_unit.v
// Operation
// R01 - low and high count bytes cascade into a 16-bit counter while running
// R02 - setting run leaves the count bytes unchanged
// R03 - software clears run before presetting count bytes
// R04 - software clears run before changing source select or mode
// R05 - source select picks peripheral cycles or falling edges on count pin
// R06 - count pin sampled once per cycle, high then low counts one
// R07 - external source holds each level at least one peripheral cycle
// R08 - gate clear: run alone enables; gate set: irq pin also gates
// R09 - rollover from all ones to zero sets the overflow flag
// R10 - mode 0: five-bit prescaler in low byte feeds 8-bit high byte
// R11 - mode 1: full 16-bit cascaded counter
// R12 - mode 2: low byte counts, reloads from unchanged high byte
// R13 - overflow flag set each overflow, cleared on interrupt vectoring
// R14 - mode 3: timer zero low byte uses its own control bits
// R15 - mode 3: timer zero high byte counts cycles, uses timer one bits
// R16 - timer one in mode 3 halts and holds its count
// R17 - software uses timer one without interrupt while timer zero split
// R18 - timer zero uses mode bits 3..0 and control bits 0,1,4,5
// R19 - timer one uses mode bits 7..4 and control bits 2,3,6,7
// R20 - interrupt needs individual enable and global enable both set
// R21 - mode field 00 13-bit, 01 16-bit, 10 reload, 11 split/halt
// R22 - gate set: count only while irq pin high and run set
// R23 - control bits 7,6 timer one flag/run; 5,4 timer zero flag/run
// R24 - mode register bit layout for gate, source select and mode
// R25 - count and gate pins pass two flip-flops before use
// R26 - hardware overflow set wins over a coincident software write
`include "timer_pair_defs.vh"
module dual_timer_counter_unit (
	// clock and reset
	input  wire       CLK_SYS,
	input  wire       RST_N,
	// external pins
	input  wire       COUNT_PIN_ZERO,
	input  wire       COUNT_PIN_ONE,
	input  wire       EXT_IRQ_ZERO_PIN,
	input  wire       EXT_IRQ_ONE_PIN,
	// special-function register writes
	input  wire [7:0] WR_DATA,
	input  wire       CTRL_WR,
	input  wire       MODE_WR,
	input  wire       T0_LOW_WR,
	input  wire       T0_HIGH_WR,
	input  wire       T1_LOW_WR,
	input  wire       T1_HIGH_WR,
	// interrupt vectoring acknowledges
	input  wire       T0_VECTOR_ACK,
	input  wire       T1_VECTOR_ACK,
	// interrupt enables
	input  wire       TIMER_ZERO_IRQ_ENABLE,
	input  wire       TIMER_ONE_IRQ_ENABLE,
	input  wire       GLOBAL_IRQ_ENABLE,
	// register read-back
	output reg  [7:0] TIMER_CONTROL_REG,
	output reg  [7:0] TIMER_MODE_REG,
	output reg  [7:0] TIMER_ZERO_LOW_BYTE,
	output reg  [7:0] TIMER_ZERO_HIGH_BYTE,
	output reg  [7:0] TIMER_ONE_LOW_BYTE,
	output reg  [7:0] TIMER_ONE_HIGH_BYTE,
	// interrupt requests to the processor
	output reg        TIMER_ZERO_IRQ,
	output reg        TIMER_ONE_IRQ
);

	////////////////////////////////////////////////////////////////////////
	// synchronised pins and peripheral cycle

	wire       cnt0_s;
	wire       cnt1_s;
	wire       timer_zero_pin_gating_s;
	wire       timer_one_pin_gating_s;
	wire       per_tick;

	// pins are asynchronous to the clock; nothing reads them unsynchronised
	pin_sync u_sync_c0 (
		.CLK_SYS     (CLK_SYS),
		.RST_N       (RST_N),
		.pin_in      (COUNT_PIN_ZERO),
		.pin_sync_out(cnt0_s)
	); // R25
	pin_sync u_sync_c1 (
		.CLK_SYS     (CLK_SYS),
		.RST_N       (RST_N),
		.pin_in      (COUNT_PIN_ONE),
		.pin_sync_out(cnt1_s)
	); // R25
	// gate pins cost two cycles of latency before they stop the count
	pin_sync u_sync_g0 (
		.CLK_SYS     (CLK_SYS),
		.RST_N       (RST_N),
		.pin_in      (EXT_IRQ_ZERO_PIN),
		.pin_sync_out(timer_zero_pin_gating_s)
	); // R25
	pin_sync u_sync_g1 (
		.CLK_SYS     (CLK_SYS),
		.RST_N       (RST_N),
		.pin_in      (EXT_IRQ_ONE_PIN),
		.pin_sync_out(timer_one_pin_gating_s)
	); // R25

	// a single clock divided into one-cycle enables keeps timing simple

	cycle_divider #(.DIV(`PER_CYCLE_DIV)) u_div (
		.CLK_SYS(CLK_SYS),
		.RST_N  (RST_N),
		.tick   (per_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// count pin sampling, one sample per peripheral cycle

	reg        samp0_reg;
	reg        samp1_reg;
	reg        fall0_reg;
	reg        fall1_reg;

	// falls are held for the whole following cycle and used on next tick;
	// samples reset low so an idle-high pin gives no false fall at start
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			samp0_reg <= 1'b0;
			samp1_reg <= 1'b0;
			fall0_reg <= 1'b0;
			fall1_reg <= 1'b0;
		end else if (per_tick) begin
			samp0_reg <= cnt0_s;
			samp1_reg <= cnt1_s;
			fall0_reg <= samp0_reg & ~cnt0_s; // R06
			fall1_reg <= samp1_reg & ~cnt1_s; // R06
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control decode

	wire [1:0] mode0 = TIMER_MODE_REG[`TMR_T0_MODE_H:`TMR_T0_MODE_L]; // R18
	wire [1:0] mode1 = TIMER_MODE_REG[`TMR_T1_MODE_H:`TMR_T1_MODE_L]; // R19
	wire       run0  = TIMER_CONTROL_REG[`TCR_T0_RUN]; // R23
	wire       run1  = TIMER_CONTROL_REG[`TCR_T1_RUN]; // R23

	// run, gate and pin combine into one enable
	function count_enable;
		input run;
		input gate;
		input pin_level;
		begin
			count_enable = run & (~gate | pin_level); // R08 R22
		end
	endfunction

	// one increment opportunity per peripheral cycle
	function source_pulse;
		input src;
		input fall;
		begin
			source_pulse = src ? fall : 1'b1; // R05
		end
	endfunction

	wire en0 = per_tick & count_enable(run0,
		TIMER_MODE_REG[`TMR_T0_GATE], timer_zero_pin_gating_s) &
		source_pulse(TIMER_MODE_REG[`TMR_T0_SRC], fall0_reg); // R24 R14
	wire en1 = per_tick & count_enable(run1,
		TIMER_MODE_REG[`TMR_T1_GATE], timer_one_pin_gating_s) &
		source_pulse(TIMER_MODE_REG[`TMR_T1_SRC], fall1_reg); // R24
	// split high byte: timer only, run from timer one's bit
	wire en0h = per_tick & run1; // R15

	////////////////////////////////////////////////////////////////////////
	// counter stepping shared by both timers

	reg  [7:0] t0l_next;
	reg  [7:0] t0h_next;
	reg  [7:0] t1l_next;
	reg  [7:0] t1h_next;
	reg        ovf0;
	reg        ovf1;

	// one stepping routine serves both timers so the modes cannot drift;
	// mode 0 holds the upper three low-byte bits, they carry no meaning
	task step_timer;
		input  [1:0] mode;
		input        en;
		input  [7:0] lo;
		input  [7:0] hi;
		output [7:0] lo_n;
		output [7:0] hi_n;
		output       ovf;
		begin
			lo_n = lo;
			hi_n = hi;
			ovf  = 1'b0;
			if (en) begin
				case (mode) // R21
				`MODE_13BIT: begin // R10
					lo_n = (lo & ~`PRESCALE_MASK) |
						((lo + `BYTE_ONE) & `PRESCALE_MASK);
					if ((lo & `PRESCALE_MASK) == `PRESCALE_TOP) begin
						hi_n = hi + `BYTE_ONE;
						ovf  = (hi == `BYTE_TOP); // R09
					end
				end
				`MODE_16BIT: begin // R01 R11
					lo_n = lo + `BYTE_ONE;
					if (lo == `BYTE_TOP) begin
						hi_n = hi + `BYTE_ONE;
						ovf  = (hi == `BYTE_TOP); // R09
					end
				end
				`MODE_RELOAD: begin // R12
					if (lo == `BYTE_TOP) begin
						lo_n = hi;
						ovf  = 1'b1;
					end else begin
						lo_n = lo + `BYTE_ONE;
					end
				end
				default: begin
					lo_n = lo;
				end
				endcase
			end
		end
	endtask

	reg        split_ovf;

	always @* begin
		split_ovf = 1'b0;
		if (mode0 == `MODE_SPLIT) begin
			// low byte counts alone with timer zero's own bits
			t0l_next = TIMER_ZERO_LOW_BYTE; // R14
			ovf0     = 1'b0;
			if (en0) begin
				t0l_next = TIMER_ZERO_LOW_BYTE + `BYTE_ONE;
				ovf0     = (TIMER_ZERO_LOW_BYTE == `BYTE_TOP);
			end
			t0h_next = TIMER_ZERO_HIGH_BYTE;
			if (en0h) begin
				t0h_next  = TIMER_ZERO_HIGH_BYTE + `BYTE_ONE; // R15
				split_ovf = (TIMER_ZERO_HIGH_BYTE == `BYTE_TOP);
			end
		end else begin
			step_timer(mode0, en0, TIMER_ZERO_LOW_BYTE,
				TIMER_ZERO_HIGH_BYTE, t0l_next, t0h_next, ovf0);
		end
		// mode 3 falls to the default hold branch
		step_timer(mode1, en1, TIMER_ONE_LOW_BYTE,
			TIMER_ONE_HIGH_BYTE, t1l_next, t1h_next, ovf1); // R16
	end

	// timer one keeps counting while split, but its flag belongs to split
	wire set_f0 = ovf0;
	wire set_f1 = (mode0 == `MODE_SPLIT) ? split_ovf : ovf1; // R15

	////////////////////////////////////////////////////////////////////////
	// registers

	// flag sets are applied last so a coincident ack or write loses;
	// a lost overflow would be worse than a repeated interrupt
	reg  [7:0] ctrl_next;

	always @* begin
		ctrl_next = TIMER_CONTROL_REG;
		if (CTRL_WR)
			ctrl_next = WR_DATA;
		if (T0_VECTOR_ACK)
			ctrl_next[`TCR_T0_OVF] = 1'b0; // R13
		if (T1_VECTOR_ACK)
			ctrl_next[`TCR_T1_OVF] = 1'b0; // R13
		if (set_f0)
			ctrl_next[`TCR_T0_OVF] = 1'b1; // R26
		if (set_f1)
			ctrl_next[`TCR_T1_OVF] = 1'b1; // R26
	end

	// count writes take the byte as written; while running the result is
	// whatever the write gives, software is expected to stop first
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			TIMER_CONTROL_REG    <= `CTRL_RESET;
			TIMER_MODE_REG       <= `MODEREG_RESET;
			TIMER_ZERO_LOW_BYTE  <= `COUNT_RESET;
			TIMER_ZERO_HIGH_BYTE <= `COUNT_RESET;
			TIMER_ONE_LOW_BYTE   <= `COUNT_RESET;
			TIMER_ONE_HIGH_BYTE  <= `COUNT_RESET;
			TIMER_ZERO_IRQ       <= 1'b0;
			TIMER_ONE_IRQ        <= 1'b0;
		end else begin
			TIMER_CONTROL_REG <= ctrl_next; // R02
			if (MODE_WR)
				TIMER_MODE_REG <= WR_DATA;
			TIMER_ZERO_LOW_BYTE  <= T0_LOW_WR  ? WR_DATA : t0l_next;
			TIMER_ZERO_HIGH_BYTE <= T0_HIGH_WR ? WR_DATA : t0h_next;
			TIMER_ONE_LOW_BYTE   <= T1_LOW_WR  ? WR_DATA : t1l_next;
			TIMER_ONE_HIGH_BYTE  <= T1_HIGH_WR ? WR_DATA : t1h_next;
			// requests follow the next flag value, so they rise with it
			TIMER_ZERO_IRQ <= ctrl_next[`TCR_T0_OVF] &
				TIMER_ZERO_IRQ_ENABLE & GLOBAL_IRQ_ENABLE; // R20
			TIMER_ONE_IRQ  <= ctrl_next[`TCR_T1_OVF] &
				TIMER_ONE_IRQ_ENABLE & GLOBAL_IRQ_ENABLE; // R20
		end
	end

endmodule

// ===== sim/dual_timer_counter_unit_checker.sv
module dual_timer_counter_unit_checker (
	input wire       CLK_SYS,
	input wire       RST_N,
	input wire       CTRL_WR,
	input wire       T0_LOW_WR,
	input wire       T0_HIGH_WR,
	input wire       T1_LOW_WR,
	input wire       T1_HIGH_WR,
	input wire       T0_VECTOR_ACK,
	input wire       TIMER_ZERO_IRQ_ENABLE,
	input wire       TIMER_ONE_IRQ_ENABLE,
	input wire       GLOBAL_IRQ_ENABLE,
	input wire [7:0] TIMER_CONTROL_REG,
	input wire [7:0] TIMER_MODE_REG,
	input wire [7:0] TIMER_ZERO_LOW_BYTE,
	input wire [7:0] TIMER_ZERO_HIGH_BYTE,
	input wire [7:0] TIMER_ONE_LOW_BYTE,
	input wire [7:0] TIMER_ONE_HIGH_BYTE,
	input wire       TIMER_ZERO_IRQ,
	input wire       TIMER_ONE_IRQ
);
	wire [7:0] tcr = TIMER_CONTROL_REG;
	wire [7:0] tmr = TIMER_MODE_REG;
	wire [7:0] l0  = TIMER_ZERO_LOW_BYTE;
	wire [7:0] h0  = TIMER_ZERO_HIGH_BYTE;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////////////////////////////////
	// low byte leaves all ones by counting, not through a write
	sequence s_l0_wrap;
		!T0_LOW_WR && !T0_HIGH_WR && l0 == 8'hFF ##1 l0 != 8'hFF;
	endsequence
	a_cascade_carry: assert property (tmr[1:0] == 2'h1 ##0 s_l0_wrap
		|-> l0 == 8'h00 && h0 == $past(h0) + 8'h01) else $error("no carry");
	a_reload_copy: assert property (tmr[1:0] == 2'h2 ##0 s_l0_wrap
		|-> l0 == h0 && tcr[5]) else $error("no reload");
	a_run_gates_low: assert property (!tcr[4] && !T0_LOW_WR
		|=> $stable(l0)) else $error("low byte moved while stopped");
	a_halt_holds: assert property (tmr[5:4] == 2'h3
		&& !T1_LOW_WR && !T1_HIGH_WR
		|=> $stable({TIMER_ONE_LOW_BYTE, TIMER_ONE_HIGH_BYTE}))
		else $error("halted timer moved");
	a_split_high: assert property (tmr[1:0] == 2'h3 && !tcr[6]
		&& !T0_HIGH_WR |=> $stable(h0)) else $error("split high moved");
	a_vector_clear: assert property (T0_VECTOR_ACK && !CTRL_WR
		&& !tcr[4] |=> !tcr[5]) else $error("flag not cleared");
	a_flag_sticky: assert property (tcr[5] && !T0_VECTOR_ACK
		&& !CTRL_WR |=> tcr[5]) else $error("flag lost");
	a_irq_zero: assert property (TIMER_ZERO_IRQ == (tcr[5]
		&& $past(TIMER_ZERO_IRQ_ENABLE) && $past(GLOBAL_IRQ_ENABLE)))
		else $error("irq zero wrong");
	a_irq_one: assert property (TIMER_ONE_IRQ == (tcr[7]
		&& $past(TIMER_ONE_IRQ_ENABLE) && $past(GLOBAL_IRQ_ENABLE)))
		else $error("irq one wrong");
endmodule

// ===== sim/count_source.sv
module count_source (
	input  wire       clk,
	input  wire [3:0] edges,
	input  wire       go,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] t = 8'h00;
	logic [3:0] n = 4'h0;
	logic       lvl = 1'b1;
	assign pin = lvl;
	// each level held two peripheral cycles so no level is missed
	always @(negedge clk) begin
		if (go) begin
			n <= edges;
			t <= 8'h00;
		end else if (n != 4'h0) begin
			t <= (t == 8'h0B) ? 8'h00 : t + 8'h01;
			if (t == 8'h0B) begin
				lvl <= ~lvl;
				if (!lvl) n <= n - 4'h1;
			end
		end
	end
endmodule

// ===== sim/dual_timer_counter_unit_tb.sv
module dual_timer_counter_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       CLK_SYS = 1'b0;
	logic       RST_N = 1'b0;
	logic       p1 = 1'b1;
	logic       g0 = 1'b1;
	logic       g1 = 1'b1;
	logic       a0 = 1'b0;
	logic       a1 = 1'b0;
	logic       e0 = 1'b0;
	logic       e1 = 1'b0;
	logic       ea = 1'b1;
	logic       go = 1'b0;
	logic [7:0] wd = 8'h00;
	logic [5:0] ws = 6'h00;
	wire        p0, q0, q1;
	wire  [7:0] tcr, tmr, l0, h0, l1, h1;
	int         num_errors = 0;
	int         total_checks = 0;
	int         cyc = 0;
	dual_timer_counter_unit i_dual_timer_counter_unit (
		.CLK_SYS(CLK_SYS), .RST_N(RST_N),
		.COUNT_PIN_ZERO(p0), .COUNT_PIN_ONE(p1),
		.EXT_IRQ_ZERO_PIN(g0), .EXT_IRQ_ONE_PIN(g1),
		.WR_DATA(wd), .CTRL_WR(ws[0]), .MODE_WR(ws[1]),
		.T0_LOW_WR(ws[2]), .T0_HIGH_WR(ws[3]),
		.T1_LOW_WR(ws[4]), .T1_HIGH_WR(ws[5]),
		.T0_VECTOR_ACK(a0), .T1_VECTOR_ACK(a1),
		.TIMER_ZERO_IRQ_ENABLE(e0), .TIMER_ONE_IRQ_ENABLE(e1),
		.GLOBAL_IRQ_ENABLE(ea),
		.TIMER_CONTROL_REG(tcr), .TIMER_MODE_REG(tmr),
		.TIMER_ZERO_LOW_BYTE(l0), .TIMER_ZERO_HIGH_BYTE(h0),
		.TIMER_ONE_LOW_BYTE(l1), .TIMER_ONE_HIGH_BYTE(h1),
		.TIMER_ZERO_IRQ(q0), .TIMER_ONE_IRQ(q1));
	count_source i_count_source (.clk(CLK_SYS), .edges(4'h3), .go(go),
		.pin(p0));
	////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// strobe index: ctrl, mode, t0 low, t0 high, t1 low, t1 high
	task wr(input int i, input logic [7:0] d);
		@(negedge CLK_SYS);
		ws <= 6'h01 << i;
		wd <= d;
		@(negedge CLK_SYS);
		ws <= 6'h00;
	endtask
	task pre(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
		wr(1, m);
		wr(2, lo);
		wr(3, hi);
	endtask
	// run for exactly n edges, so any phase of the divider gives n/6 ticks;
	// the stop write keeps the flags, overflow lands well before it
	task run(input logic [7:0] c, input int n);
		wr(0, c);
		repeat (n - 2) @(negedge CLK_SYS);
		wr(0, tcr & 8'hAF);
	endtask
	////////////////////////////////////////////////////////////////////
	task t_mode1;
		pre(8'h01, 8'hFE, 8'hFF);
		e0 <= 1'b1;
		run(8'h10, 24);
		chk({l0, h0, tcr, 7'h0, q0}, 32'h02002001);
		ea <= 1'b0;
		@(negedge CLK_SYS);
		chk(q0, 0);
		a0 <= 1'b1;
		@(negedge CLK_SYS);
		a0 <= 1'b0;
		chk(tcr, 8'h00);
		$display("mode1 test done");
	endtask
	task t_prescale_reload;
		pre(8'h00, 8'hFE, 8'hFF);
		run(8'h10, 24);
		chk({l0, h0, tcr}, 32'hE20020);
		wr(0, 8'h00);
		pre(8'h02, 8'hFE, 8'hF0);
		run(8'h10, 24);
		chk({l0, h0, tcr}, 32'hF2F020);
		$display("prescale and reload test done");
	endtask
	task t_split;
		pre(8'h33, 8'h11, 8'hFE);
		wr(4, 8'h55);
		wr(5, 8'h66);
		e1 <= 1'b1;
		ea <= 1'b1;
		run(8'h50, 24);
		chk({l0, h0, l1, h1}, 32'h15025566);
		chk({tcr, 7'h0, q1}, 16'h8001);
		a1 <= 1'b1;
		@(negedge CLK_SYS);
		a1 <= 1'b0;
		chk(tcr, 8'h00);
		$display("split test done");
	endtask
	task t_timer1;
		wr(1, 8'h10);
		wr(4, 8'hFE);
		wr(5, 8'hFF);
		run(8'h40, 24);
		chk({l1, h1, tcr, 7'h0, q1}, 32'h02008001);
		chk(tmr, 8'h10);
		$display("timer one test done");
	endtask
	task t_gate;
		g0 <= 1'b0;
		pre(8'h09, 8'h00, 8'h00);
		run(8'h10, 24);
		chk(l0, 8'h00);
		g0 <= 1'b1;
		repeat (4) @(negedge CLK_SYS);
		run(8'h10, 24);
		chk(l0, 8'h04);
		$display("gate test done");
	endtask
	task t_count;
		pre(8'h05, 8'h00, 8'h00);
		wr(0, 8'h10);
		go <= 1'b1;
		@(negedge CLK_SYS);
		go <= 1'b0;
		repeat (100) @(negedge CLK_SYS);
		wr(0, 8'h00);
		chk(l0, 8'h03);
		$display("count pin test done");
	endtask
	task final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			final_report;
		end
	end
	initial begin
		repeat (16) @(negedge CLK_SYS);
		RST_N <= 1'b1;
		@(negedge CLK_SYS);
		chk({tcr, tmr, l0, h0}, 32'h0);
		chk({l1, h1, 6'h0, q0, q1}, 32'h0);
		t_mode1;
		t_prescale_reload;
		t_split;
		t_timer1;
		t_gate;
		t_count;
		final_report;
	end
endmodule
bind dual_timer_counter_unit dual_timer_counter_unit_checker
	i_dual_timer_counter_unit_checker (.*);
